// ==== rtl/cmei_pkg.sv ====
package cmei_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_FLAGS_LOW = 8'h00;
    localparam logic [7:0] OFS_FLAGS_HIGH = 8'h04;
    localparam logic [7:0] OFS_COMP_INFO = 8'h08;
    localparam logic [7:0] OFS_EVENT_FLAG = 8'h0c;
    localparam logic [7:0] OFS_ERR_INFO = 8'h10;
    localparam logic [7:0] OFS_CONFIG = 8'h14;
    localparam logic [7:0] OFS_INT_EN = 8'h18;
    // Event flag register bit positions
    localparam int BIT_RX_DONE = 0;
    localparam int BIT_TX_DONE = 1;
    localparam int BIT_BUF_FULL = 2;
    localparam int BIT_MSG_ERR = 3;
    localparam int BIT_FRM_ERR = 4;
    // Per-object control: interrupt enable position
    localparam int CTL_INT_EN_BIT = 3;
    // Completion info fields
    localparam int INFO_ANY_BIT = 5;
    // Buffer-full thresholds
    localparam logic [8:0] ROOM_PROTO = 9'h007;
    localparam logic [8:0] ROOM_PLAIN = 9'h009;
    // Buffer locations
    localparam logic [7:0] LOC_COUNT = 8'h00;
    localparam logic [7:0] LOC_FIRST = 8'h01;
    // Reset values
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    // Protocol selection
    typedef enum logic [1:0]
    {
        CMEI_PLAIN = 2'h0,
        CMEI_PROTO_A = 2'h1,
        CMEI_PROTO_B = 2'h2,
        CMEI_PROTO_C = 2'h3
    } cmei_proto_t;
    // Error types
    localparam logic ERR_UNDERFLOW = 1'b0;
    localparam logic ERR_FRAGMENT = 1'b1;
    // Frame-end event from the receive engine
    typedef struct packed
    {
        logic valid;
        logic [4:0] obj;
        logic start;
        logic last;
        logic [5:0] frag;
        logic [7:0] bytes;
    } cmei_rx_evt_t;
    // Byte-count write toward the message buffer
    typedef struct packed
    {
        logic valid;
        logic [4:0] obj;
        logic [7:0] loc;
        logic [7:0] data;
    } cmei_buf_wr_t;
endpackage

// ==== rtl/cmei_prio.sv ====
`timescale 1ns/1ps
// Lowest set bit finder
module cmei_prio
    import cmei_pkg::*;
#(
    parameter int N = 32
)
(
    // Request vector
    input wire logic [N-1:0] req_i,
    // Encoded answer
    output logic [4:0] idx_o,
    output logic any_o
);
    // Scan from the top so the lowest wins
    always_comb
    begin
        idx_o = 5'h00;
        any_o = 1'b0;
        for (int i = N - 1; i >= 0; i--)
        begin
            if (req_i[i])
            begin
                idx_o = 5'(i);
                any_o = 1'b1;
            end
        end
    end
endmodule

// ==== rtl/cmei_core.sv ====
`timescale 1ns/1ps
// Overview of operation
// - Five separate event interrupt request outputs
// - Rx complete at message end only
// - Tx complete at every good frame
// - Int enable register bit per object enables interrupt
// - Status flag always set on completion
// - Tx/Rx interrupt flags at bits 1/0
// - Interrupt set with status if enabled
// - Status flags cleared by writing one
// - Irq flag cleared by one; new event sets it again
// - Info gives lowest enabled pending object
// - Protocols: full below seven bytes room
// - Plain mode: below nine, no count
// - Full check only on non-last frames
// - On full write count (not in plain mode), wrap, interrupt
// - After wrap count restarts from zero
// - Underflow/fragment error sets bit 3
// - Message error flag cleared by one
// - Underflow when transmit engine starves
// - Fragment count must advance by one
// - New start restarts assembly silently
module cmei_core
    import cmei_pkg::*;
#(
    parameter int NOBJ = 32
)
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Engine events
    input cmei_rx_evt_t rx_evt_i,
    input wire logic tx_done_i,
    input wire logic [4:0] tx_obj_i,
    input wire logic tx_underflow_i,
    input wire logic frame_err_i,
    // Buffer room of each frame end object
    input wire logic [8:0] rx_room_i,
    // Byte count and pointer writes
    output cmei_buf_wr_t buf_wr_o,
    output logic ptr_reset_o,
    // Event interrupt requests
    output logic irq_rx_done_o,
    output logic irq_tx_done_o,
    output logic irq_buf_full_o,
    output logic irq_msg_err_o,
    output logic irq_frm_err_o
);
    // Status and flags
    logic [NOBJ-1:0] done_flags;
    logic [NOBJ-1:0] next_done_flags;
    logic [NOBJ-1:0] int_en;
    logic [NOBJ-1:0] next_int_en;
    logic [4:0] ev_flags;
    logic [4:0] next_ev_flags;
    logic [7:0] err_info;
    logic [7:0] next_err_info;
    logic [1:0] proto;
    logic [1:0] next_proto;
    // Per-object assembly state
    logic [NOBJ-1:0] busy;
    logic [NOBJ-1:0] next_busy;
    logic [5:0] frag_prev [NOBJ];
    logic [5:0] next_frag_prev [NOBJ];
    logic [7:0] count [NOBJ];
    logic [7:0] next_count [NOBJ];
    // Outputs toward buffer
    cmei_buf_wr_t buf_wr;
    cmei_buf_wr_t next_buf_wr;
    logic ptr_reset;
    logic next_ptr_reset;
    // Bus data phase capture
    logic ph_wr;
    logic ph_rd;
    logic [7:0] ph_addr;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    // Completion info
    logic [4:0] low_idx;
    logic low_any;
    logic [7:0] comp_info;

    // Encoder over enabled pending objects
    cmei_prio #(.N(NOBJ)) u_prio
    (
        .req_i(done_flags & int_en),
        .idx_o(low_idx),
        .any_o(low_any)
    );

    // Bits 6 and 7 read as zero
    assign comp_info = {2'b00, low_any, low_idx};

    // Address phase capture
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ph_wr <= 1'b0;
            ph_rd <= 1'b0;
            ph_addr <= 8'h00;
        end
        else if (hready_i)
        begin
            ph_wr <= hsel_i & htrans_i[1] & hwrite_i;
            ph_rd <= hsel_i & htrans_i[1] & ~hwrite_i;
            ph_addr <= haddr_i;
        end
    end

    // Main next-state logic
    always_comb
    begin
        logic [5:0] want;
        logic [8:0] thresh;
        logic [4:0] o;
        logic tx_done_set;
        logic rx_done_set;
        logic frag_bad;
        logic full;
        logic [7:0] newcnt;
        want = 6'h00;
        thresh = ROOM_PROTO;
        o = rx_evt_i.obj;
        tx_done_set = 1'b0;
        rx_done_set = 1'b0;
        frag_bad = 1'b0;
        full = 1'b0;
        newcnt = 8'h00;
        next_done_flags = done_flags;
        next_int_en = int_en;
        next_ev_flags = ev_flags;
        next_err_info = err_info;
        next_proto = proto;
        next_busy = busy;
        next_frag_prev = frag_prev;
        next_count = count;
        next_buf_wr = '0;
        next_ptr_reset = 1'b0;
        next_rdata = 32'h0000_0000;
        // Software writes: flags one clears, zero leaves; config and enables load
        if (ph_wr)
        begin
            case (ph_addr)
                OFS_FLAGS_LOW:
                    next_done_flags[15:0] =
                        done_flags[15:0] & ~hwdata_i[15:0];
                OFS_FLAGS_HIGH:
                    next_done_flags[31:16] =
                        done_flags[31:16] & ~hwdata_i[15:0];
                OFS_EVENT_FLAG:
                    next_ev_flags = ev_flags & ~hwdata_i[4:0];
                OFS_CONFIG:
                    next_proto = hwdata_i[1:0];
                OFS_INT_EN:
                    next_int_en = hwdata_i;
                default:
                    next_proto = next_proto;
            endcase
        end
        // Transmit: every good frame completes
        if (tx_done_i)
        begin
            next_done_flags[tx_obj_i] = 1'b1;
            tx_done_set = int_en[tx_obj_i];
        end
        // Receive frame end handling
        if (rx_evt_i.valid)
        begin
            case (cmei_proto_t'(proto))
                CMEI_PROTO_A: want = frag_prev[o] + 6'h01;
                CMEI_PROTO_B: want = {2'b00, frag_prev[o][3:0] + 4'h1};
                CMEI_PROTO_C: want = {5'h00, ~frag_prev[o][0]};
                default: want = frag_prev[o] + 6'h01;
            endcase
            thresh = (proto == CMEI_PLAIN) ? ROOM_PLAIN : ROOM_PROTO;
            newcnt = (rx_evt_i.start ? 8'h00 : count[o]) + rx_evt_i.bytes;
            if (rx_evt_i.start)
            begin
                // Restart, no fragment error raised
                next_count[o] = rx_evt_i.bytes;
                next_busy[o] = ~rx_evt_i.last;
            end
            else if (busy[o] && rx_evt_i.frag != want)
            begin
                frag_bad = 1'b1;
                next_busy[o] = 1'b0;
            end
            else
                next_count[o] = newcnt;
            next_frag_prev[o] = rx_evt_i.frag;
            if (rx_evt_i.last && !frag_bad)
            begin
                // Message end only
                next_done_flags[o] = 1'b1;
                rx_done_set = int_en[o];
                next_busy[o] = 1'b0;
                next_buf_wr = '{1'b1, o, LOC_COUNT, newcnt};
            end
            else if (!frag_bad && rx_room_i < thresh)
            begin
                full = 1'b1;
                next_ptr_reset = 1'b1;
                next_count[o] = 8'h00;
                if (proto != CMEI_PLAIN)
                    next_buf_wr = '{1'b1, o, LOC_COUNT, newcnt};
            end
        end
        // Set wins over a same-cycle clear
        if (tx_done_set)
            next_ev_flags[BIT_TX_DONE] = 1'b1;
        if (rx_done_set)
            next_ev_flags[BIT_RX_DONE] = 1'b1;
        if (full)
            next_ev_flags[BIT_BUF_FULL] = 1'b1;
        if (frame_err_i)
            next_ev_flags[BIT_FRM_ERR] = 1'b1;
        if (frag_bad)
        begin
            next_ev_flags[BIT_MSG_ERR] = 1'b1;
            next_err_info = {2'b00, ERR_FRAGMENT, o};
        end
        else if (tx_underflow_i)
        begin
            next_ev_flags[BIT_MSG_ERR] = 1'b1;
            next_err_info = {2'b00, ERR_UNDERFLOW, tx_obj_i};
        end
        // Read data for next data phase
        if (hsel_i && htrans_i[1] && !hwrite_i && hready_i)
        begin
            case (haddr_i)
                OFS_FLAGS_LOW: next_rdata = {16'h0000, done_flags[15:0]};
                OFS_FLAGS_HIGH: next_rdata = {16'h0000, done_flags[31:16]};
                OFS_COMP_INFO: next_rdata = {24'h000000, comp_info};
                OFS_EVENT_FLAG: next_rdata = {27'h0, ev_flags};
                OFS_ERR_INFO: next_rdata = {24'h000000, err_info};
                OFS_CONFIG: next_rdata = {30'h0, proto};
                OFS_INT_EN: next_rdata = int_en;
                default: next_rdata = 32'h0000_0000;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            done_flags <= '0;
            int_en <= '0;
            ev_flags <= 5'h00;
            err_info <= 8'h00;
            proto <= 2'h0;
            busy <= '0;
            for (int i = 0; i < NOBJ; i++)
            begin
                frag_prev[i] <= 6'h00;
                count[i] <= 8'h00;
            end
            buf_wr <= '0;
            ptr_reset <= 1'b0;
            rdata <= RST_WORD;
        end
        else
        begin
            done_flags <= next_done_flags;
            int_en <= next_int_en;
            ev_flags <= next_ev_flags;
            err_info <= next_err_info;
            proto <= next_proto;
            busy <= next_busy;
            frag_prev <= next_frag_prev;
            count <= next_count;
            buf_wr <= next_buf_wr;
            ptr_reset <= next_ptr_reset;
            rdata <= next_rdata;
        end
    end

    // Outputs straight from flops; hready and hresp constant
    assign hrdata_o = rdata;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign buf_wr_o = buf_wr;
    assign ptr_reset_o = ptr_reset;
    assign irq_rx_done_o = ev_flags[BIT_RX_DONE];
    assign irq_tx_done_o = ev_flags[BIT_TX_DONE];
    assign irq_buf_full_o = ev_flags[BIT_BUF_FULL];
    assign irq_msg_err_o = ev_flags[BIT_MSG_ERR];
    assign irq_frm_err_o = ev_flags[BIT_FRM_ERR];

    // Assertions
    a_tx_flag_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tx_done_i |=> done_flags[$past(tx_obj_i)])
        else $error("tx status flag not set");
    a_tx_irq_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tx_done_i && int_en[tx_obj_i] |=> irq_tx_done_o)
        else $error("tx irq not raised");
    a_rx_irq_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        rx_evt_i.valid && rx_evt_i.last && rx_evt_i.start
        && int_en[rx_evt_i.obj] |=> irq_rx_done_o)
        else $error("rx irq not raised");
    a_info_any: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        comp_info[INFO_ANY_BIT] == |(done_flags & int_en))
        else $error("info any bit wrong");
    a_info_low: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        low_any |-> done_flags[low_idx] && int_en[low_idx]
        && ((done_flags & int_en & ((32'h1 << low_idx) - 1)) == 0))
        else $error("info index wrong");
    a_err_set: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        tx_underflow_i |=> irq_msg_err_o)
        else $error("message error not raised");
    a_irq_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        irq_rx_done_o && !ph_wr |=> irq_rx_done_o)
        else $error("rx irq dropped by itself");
    a_full_wrap: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        $rose(irq_buf_full_o) |-> ptr_reset)
        else $error("full without pointer reset");
    a_plain_nocount: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        ptr_reset && $past(proto) == CMEI_PLAIN |-> !buf_wr.valid)
        else $error("count written in plain mode");

    // Restart with ample room and no other event
    sequence s_quiet_restart;
        rx_evt_i.valid && rx_evt_i.start && !rx_evt_i.last
        && rx_room_i >= ROOM_PLAIN && !ph_wr && !tx_done_i
        && !tx_underflow_i && !frame_err_i;
    endsequence
    // No flag may move one edge later
    a_restart_quiet: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        s_quiet_restart |=> $stable(ev_flags))
        else $error("restart raised a flag");
endmodule

// ==== verification/cmei_cpu_model.sv ====
`timescale 1ns/1ps
// Processor side: AHB-Lite master that services events
module cmei_cpu_model
    import cmei_pkg::*;
(
    // Clock and slave answer
    input wire logic clk_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_i,
    // Request signals
    output logic [7:0] haddr_o,
    output logic [1:0] htrans_o,
    output logic hwrite_o,
    output logic [2:0] hsize_o,
    output logic [31:0] hwdata_o,
    // A wait ran past its bound
    output logic hung_o
);
    // Idle bus at time zero
    initial
    begin
        haddr_o = 8'h00;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
        hsize_o = 3'h2;
        hwdata_o = 32'h0;
        hung_o = 1'b0;
    end
    // Next edge with hready high, bounded
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge clk_i);
        while (hready_i !== 1'b1 && n < 64)
        begin
            n++;
            @(posedge clk_i);
        end
        if (n >= 64)
            hung_o <= 1'b1;
    endtask
    // One single word transfer, address then data phase
    task automatic xfer(input logic [7:0] a, input logic w,
                        input logic [31:0] wd, output logic [31:0] rd);
        // Start just after a rising edge
        @(posedge clk_i);
        haddr_o <= a;
        hwrite_o <= w;
        htrans_o <= 2'h2;
        wait_rdy();
        htrans_o <= 2'h0;
        hwdata_o <= wd;
        wait_rdy();
        rd = hrdata_i;
    endtask
    // Service routine: status flags first, event flag last
    task automatic service(input logic [7:0] a, input logic [31:0] m,
                           input int b);
        logic [31:0] d;
        xfer(a, 1'b1, m, d);
        xfer(OFS_EVENT_FLAG, 1'b1, 32'h1 << b, d);
    endtask
endmodule

// ==== verification/cmei_core_tb.sv ====
`timescale 1ns/1ps
// Self-checking bench for the event interrupt core
module cmei_core_tb
    import cmei_pkg::*;
;
    logic clk_i, sys_rst_i, hready, hresp, hwrite, hung, ptr_rst;
    logic [7:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, d;
    logic [2:0] evk;
    logic [4:0] tx_obj, irq;
    logic [8:0] room;
    cmei_rx_evt_t rx_evt;
    cmei_buf_wr_t buf_wr;
    int n_mismatch = 0;
    int check_count = 0;
    cmei_core uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .hsel_i(1'b1),
        .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready),
        .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .rx_evt_i(rx_evt), .tx_done_i(evk[0]), .tx_obj_i(tx_obj),
        .tx_underflow_i(evk[1]), .frame_err_i(evk[2]),
        .rx_room_i(room), .buf_wr_o(buf_wr), .ptr_reset_o(ptr_rst),
        .irq_rx_done_o(irq[0]), .irq_tx_done_o(irq[1]),
        .irq_buf_full_o(irq[2]), .irq_msg_err_o(irq[3]),
        .irq_frm_err_o(irq[4]));
    cmei_cpu_model cpu (.clk_i(clk_i), .hready_i(hready),
        .hrdata_i(hrdata), .haddr_o(haddr), .htrans_o(htrans),
        .hwrite_o(hwrite), .hsize_o(hsize), .hwdata_o(hwdata),
        .hung_o(hung));
    // Free-running 50 ns clock
    initial
    begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end
    // Compare and count
    task automatic ck(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // Register read with comparison
    task automatic rck(input logic [7:0] a, input logic [31:0] e);
        cpu.xfer(a, 1'b0, 32'h0, d);
        ck("reg", e, d);
    endtask
    // Register write, effect visible after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        cpu.xfer(a, 1'b1, v, d);
        #1;
    endtask
    // Receive frame end pulse
    task automatic rx(input logic [4:0] o, input logic s, l,
        input logic [5:0] f, input logic [7:0] b, input logic [8:0] r);
        @(posedge clk_i);
        rx_evt <= '{1'b1, o, s, l, f, b};
        room <= r;
        @(posedge clk_i);
        rx_evt <= '0;
        #1;
    endtask
    // Transmit side pulse: 1 done, 2 underflow, 4 frame error
    task automatic tx(input logic [4:0] o, input logic [2:0] k);
        @(posedge clk_i);
        tx_obj <= o;
        evk <= k;
        @(posedge clk_i);
        evk <= 3'h0;
        #1;
    endtask
    // Closing report
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // A bus wait that ran out ends the run
    always @(posedge hung)
    begin
        n_mismatch++;
        results();
    end
    // Reset state and unmapped access
    task automatic t_reset();
        ck("irq", 5'h00, irq);
        ck("hresp", 1'b0, hresp);
        rck(OFS_COMP_INFO, 32'h0);
        rck(8'h40, 32'h0);
        $display("t_reset done");
    endtask
    // Completion, enables and lowest pending object
    task automatic t_complete();
        wr(OFS_CONFIG, 32'h1);
        wr(OFS_INT_EN, 32'h0002_0020);
        rx(5'd5, 1'b1, 1'b0, 6'h00, 8'h08, 9'h064);
        ck("rx_irq", 1'b0, irq[0]);
        rx(5'd5, 1'b0, 1'b1, 6'h01, 8'h04, 9'h064);
        ck("rx_irq", 1'b1, irq[0]);
        rx(5'd2, 1'b1, 1'b1, 6'h00, 8'h03, 9'h064);
        tx(5'd17, 3'h1);
        ck("tx_irq", 1'b1, irq[1]);
        rck(OFS_FLAGS_LOW, 32'h24);
        rck(OFS_FLAGS_HIGH, 32'h2);
        rck(OFS_COMP_INFO, 32'h25);
        rck(OFS_EVENT_FLAG, 32'h3);
        $display("t_complete done");
    endtask
    // Clearing by writing one, early clear not re-armed
    task automatic t_clear();
        wr(OFS_EVENT_FLAG, 32'h1);
        ck("rx_irq", 1'b0, irq[0]);
        rx(5'd2, 1'b1, 1'b1, 6'h00, 8'h03, 9'h064);
        ck("rx_irq", 1'b0, irq[0]);
        cpu.service(OFS_FLAGS_LOW, 32'h24, BIT_RX_DONE);
        rck(OFS_FLAGS_LOW, 32'h0);
        wr(OFS_FLAGS_HIGH, 32'h0);
        rck(OFS_FLAGS_HIGH, 32'h2);
        cpu.service(OFS_FLAGS_HIGH, 32'h2, BIT_TX_DONE);
        #1;
        ck("tx_irq", 1'b0, irq[1]);
        rck(OFS_COMP_INFO, 32'h0);
        $display("t_clear done");
    endtask
    // Buffer full thresholds, wrap and counts
    task automatic t_buf_full();
        rx(5'd3, 1'b1, 1'b0, 6'h00, 8'h05, 9'h007);
        ck("ptr", 1'b0, ptr_rst);
        rx(5'd3, 1'b0, 1'b0, 6'h01, 8'h06, 9'h006);
        ck("ptr", 1'b1, ptr_rst);
        ck("bwr", {1'b1, 5'd3, 8'h00, 8'h0b}, buf_wr);
        ck("bf_irq", 1'b1, irq[2]);
        rx(5'd3, 1'b0, 1'b1, 6'h02, 8'h04, 9'h002);
        ck("ptr", 1'b0, ptr_rst);
        ck("bwr", {1'b1, 5'd3, 8'h00, 8'h04}, buf_wr);
        wr(OFS_EVENT_FLAG, 32'h4);
        wr(OFS_CONFIG, 32'h0);
        rx(5'd7, 1'b1, 1'b0, 6'h00, 8'h08, 9'h009);
        ck("ptr", 1'b0, ptr_rst);
        rx(5'd7, 1'b1, 1'b0, 6'h00, 8'h08, 9'h008);
        ck("ptr", 1'b1, ptr_rst);
        ck("bwv", 1'b0, buf_wr.valid);
        ck("bf_irq", 1'b1, irq[2]);
        $display("t_buf_full done");
    endtask
    // Message errors, restart and frame error
    task automatic t_errors();
        wr(OFS_CONFIG, 32'h1);
        tx(5'd9, 3'h2);
        ck("me_irq", 1'b1, irq[3]);
        rck(OFS_ERR_INFO, 32'h09);
        wr(OFS_EVENT_FLAG, 32'h8);
        ck("me_irq", 1'b0, irq[3]);
        rx(5'd4, 1'b1, 1'b0, 6'h00, 8'h08, 9'h064);
        rx(5'd4, 1'b1, 1'b0, 6'h00, 8'h08, 9'h064);
        ck("irq", 5'h04, irq);
        rx(5'd4, 1'b0, 1'b0, 6'h02, 8'h08, 9'h064);
        ck("me_irq", 1'b1, irq[3]);
        rck(OFS_ERR_INFO, 32'h24);
        tx(5'd0, 3'h4);
        ck("fe_irq", 1'b1, irq[4]);
        wr(OFS_EVENT_FLAG, 32'h8);
        wr(OFS_CONFIG, 32'h2);
        rx(5'd6, 1'b1, 1'b0, 6'h0f, 8'h08, 9'h064);
        rx(5'd6, 1'b0, 1'b0, 6'h00, 8'h08, 9'h064);
        ck("me_irq", 1'b0, irq[3]);
        wr(OFS_CONFIG, 32'h3);
        rx(5'd8, 1'b1, 1'b0, 6'h00, 8'h08, 9'h064);
        rx(5'd8, 1'b0, 1'b0, 6'h00, 8'h08, 9'h064);
        ck("me_irq", 1'b1, irq[3]);
        rck(OFS_ERR_INFO, 32'h28);
        rx(5'd5, 1'b1, 1'b1, 6'h00, 8'h03, 9'h064);
        ck("rx_irq", 1'b1, irq[0]);
        $display("t_errors done");
    endtask
    // Main sequence
    initial
    begin
        sys_rst_i = 1'b1;
        rx_evt = '0;
        evk = 3'h0;
        tx_obj = 5'd0;
        room = 9'h064;
        repeat (3) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_complete();
        t_clear();
        t_buf_full();
        t_errors();
        results();
    end
endmodule
